// ### design/rafc_top.sv
// Added by the designer: strobed register access and the address map.
`timescale 1ns/100ps
`default_nettype none
module rafc_top #(
   parameter bit P_HIGH_VOLT  = 1'b0,
   parameter int P_STEP_CYC   = rafc_pkg::STEP_CYC,
   parameter int P_DLY_UNIT   = rafc_pkg::DLY_UNIT_CYC
) (
   input  wire logic                          i_clk,
   input  wire logic                          i_sys_rst,
   input  wire logic [rafc_pkg::ADDR_W-1:0]   i_addr,
   input  wire logic [rafc_pkg::DATA_W-1:0]   i_wdata,
   input  wire logic                          i_wr,
   input  wire logic                          i_rd,
   output logic      [rafc_pkg::DATA_W-1:0]   o_rdata,
   input  wire logic [rafc_pkg::VOLT_W-1:0]   i_bus_voltage,
   input  wire logic [rafc_pkg::FREQ_W-1:0]   i_cmd_freq,
   input  wire logic                          i_accel,
   input  wire logic                          i_const,
   input  wire logic                          i_decel,
   input  wire logic                          i_ov_stall_hold,
   output logic      [rafc_pkg::FREQ_W-1:0]   o_out_freq,
   output logic                               o_ov_stall_ind,
   output logic                               o_stall_prev,
   output logic                               o_stall_out,
   output logic                               o_irq
);
   // ===========================================
   // declarations
   rafc_pkg::rafc_cfg_t            cfg;
   rafc_pkg::rafc_state_t          state;
   rafc_pkg::rafc_state_t          next_state;
   logic                           extsel;
   logic [rafc_pkg::ST_W-1:0]      status;
   logic [rafc_pkg::ST_W-1:0]      ien;
   logic [rafc_pkg::FREQ_W-1:0]    comp;
   logic [rafc_pkg::FREQ_W-1:0]    next_comp;
   logic [31:0]                    step_cnt;
   logic                           tick;
   logic                           enable;
   logic                           regen;
   logic                           regen_q;
   logic                           unlimited;
   logic                           lim_hit;
   logic                           max_hit;
   logic [rafc_pkg::FREQ_W-1:0]    rise;
   logic [rafc_pkg::FREQ_W-1:0]    fall;
   logic [rafc_pkg::FREQ_W-1:0]    raw;
   logic [rafc_pkg::FREQ_W-1:0]    room;
   logic [rafc_pkg::FREQ_W-1:0]    half_lim;
   logic [rafc_pkg::FREQ_W:0]      sum;
   logic [31:0]                    unit_cnt;
   logic [rafc_pkg::FREQ_W-1:0]    dly_cnt;
   logic                           wr_ok;
   logic [rafc_pkg::ST_W-1:0]      ev;

   // ===========================================
   // helpers
   function automatic logic [rafc_pkg::FREQ_W-1:0] gain_step(
      input logic [rafc_pkg::VOLT_W-1:0] dv,
      input logic [rafc_pkg::PCT_W-1:0]  vg,
      input logic [rafc_pkg::PCT_W-1:0]  fg
   );
      logic [25:0] p;
      p = 26'(dv) * 26'(vg) * 26'(fg);
      p = p >> rafc_pkg::GAIN_SHIFT;
      gain_step = (p > 26'(rafc_pkg::FREQ_TOP)) ? rafc_pkg::FREQ_TOP
                                                 : p[rafc_pkg::FREQ_W-1:0];
   endfunction

   function automatic logic [rafc_pkg::FREQ_W-1:0] fmin(
      input logic [rafc_pkg::FREQ_W-1:0] a,
      input logic [rafc_pkg::FREQ_W-1:0] b
   );
      fmin = (a < b) ? a : b;
   endfunction

   // ===========================================
   // register writes
   assign wr_ok = i_wr && (extsel == 1'b0);

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         cfg.mode  <= rafc_pkg::MODE_OFF;
         cfg.level <= P_HIGH_VOLT ? rafc_pkg::LEVEL_RST_H : rafc_pkg::LEVEL_RST_L;
         cfg.limit <= rafc_pkg::LIMIT_RST;
         cfg.vgain <= rafc_pkg::GAIN_RST;
         cfg.fgain <= rafc_pkg::GAIN_RST;
         cfg.maxf  <= rafc_pkg::MAXF_RST;
         cfg.stsel <= 1'b1;
         cfg.stdly <= '0;
      end else if (wr_ok) begin
         unique case (i_addr)
            rafc_pkg::REG_MODE: begin
               if (i_wdata[1:0] != 2'h3) begin
                  cfg.mode <= i_wdata[1:0];
               end
            end
            rafc_pkg::REG_LEVEL: begin
               if (i_wdata >= 16'(rafc_pkg::LEVEL_MIN) &&
                   i_wdata <= 16'(rafc_pkg::LEVEL_MAX)) begin
                  cfg.level <= i_wdata[rafc_pkg::VOLT_W-1:0];
               end
            end
            rafc_pkg::REG_LIMIT: begin
               if (i_wdata <= rafc_pkg::LIMIT_MAX ||
                   i_wdata == rafc_pkg::LIMIT_OFF) begin
                  cfg.limit <= i_wdata;
               end
            end
            rafc_pkg::REG_VGAIN: begin
               if (i_wdata <= 16'(rafc_pkg::GAIN_MAX)) begin
                  cfg.vgain <= i_wdata[rafc_pkg::PCT_W-1:0];
               end
            end
            rafc_pkg::REG_FGAIN: begin
               if (i_wdata <= 16'(rafc_pkg::GAIN_MAX)) begin
                  cfg.fgain <= i_wdata[rafc_pkg::PCT_W-1:0];
               end
            end
            rafc_pkg::REG_MAXF:  cfg.maxf  <= i_wdata;
            rafc_pkg::REG_STSEL: cfg.stsel <= i_wdata[0];
            rafc_pkg::REG_STDLY: cfg.stdly <= i_wdata;
            default: ;
         endcase
      end
   end

   // display selection itself is always writable
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         extsel <= 1'b0;
      end else if (i_wr && i_addr == rafc_pkg::REG_EXTSEL) begin
         extsel <= i_wdata[0];
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         ien <= '0;
      end else if (wr_ok && i_addr == rafc_pkg::REG_IEN) begin
         ien <= i_wdata[rafc_pkg::ST_W-1:0];
      end
   end

   // ===========================================
   // register reads, data one cycle later
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_rdata <= '0;
      end else if (i_rd) begin
         unique case (i_addr)
            rafc_pkg::REG_MODE:   o_rdata <= 16'(cfg.mode);
            rafc_pkg::REG_LEVEL:  o_rdata <= 16'(cfg.level);
            rafc_pkg::REG_LIMIT:  o_rdata <= cfg.limit;
            rafc_pkg::REG_VGAIN:  o_rdata <= 16'(cfg.vgain);
            rafc_pkg::REG_FGAIN:  o_rdata <= 16'(cfg.fgain);
            rafc_pkg::REG_MAXF:   o_rdata <= cfg.maxf;
            rafc_pkg::REG_EXTSEL: o_rdata <= 16'(extsel);
            rafc_pkg::REG_STSEL:  o_rdata <= 16'(cfg.stsel);
            rafc_pkg::REG_STDLY:  o_rdata <= cfg.stdly;
            rafc_pkg::REG_STAT:   o_rdata <= 16'(status);
            rafc_pkg::REG_IEN:    o_rdata <= 16'(ien);
            rafc_pkg::REG_FREQ:   o_rdata <= o_out_freq;
            rafc_pkg::REG_LIVE:   o_rdata <= comp;
            default:              o_rdata <= '0;
         endcase
      end else begin
         o_rdata <= '0;
      end
   end

   // ===========================================
   // regeneration detect
   always_comb begin
      unique case (cfg.mode)
         rafc_pkg::MODE_ALWAYS: enable = 1'b1;
         rafc_pkg::MODE_CONST:  enable = i_const || i_ov_stall_hold;
         default:               enable = 1'b0;
      endcase
   end

   assign regen = enable && (i_bus_voltage >= cfg.level);

   // update pacing
   always_ff @(posedge i_clk) begin
      if (i_sys_rst || tick) begin
         step_cnt <= '0;
      end else begin
         step_cnt <= step_cnt + 32'h0000_0001;
      end
   end

   assign tick = (step_cnt == 32'(P_STEP_CYC - 1));

   // ===========================================
   // compensation arithmetic
   assign unlimited = (cfg.limit == rafc_pkg::LIMIT_OFF);
   assign half_lim  = cfg.limit >> 1;
   assign rise = gain_step(i_bus_voltage - cfg.level, cfg.vgain, cfg.fgain);
   assign fall = enable ? gain_step(cfg.level - i_bus_voltage, cfg.vgain, cfg.fgain)
                        : rafc_pkg::FREQ_TOP;
   assign room = (i_cmd_freq >= cfg.maxf) ? '0 : cfg.maxf - i_cmd_freq;

   always_comb begin
      sum = 17'(comp) + 17'(rise);
      if (regen) begin
         raw = sum[rafc_pkg::FREQ_W] ? rafc_pkg::FREQ_TOP : sum[rafc_pkg::FREQ_W-1:0];
      end else begin
         raw = comp - fmin(comp, fall);
      end
   end

   assign lim_hit = !unlimited && (raw > cfg.limit);

   always_comb begin
      next_state = state;
      next_comp  = comp;
      if (cfg.mode == rafc_pkg::MODE_OFF) begin
         next_state = rafc_pkg::RAFC_IDLE;
         next_comp  = '0;
      end else if (tick) begin
         unique case (state)
            rafc_pkg::RAFC_IDLE: begin
               if (regen) begin
                  next_state = rafc_pkg::RAFC_COMP;
                  next_comp  = fmin(lim_hit ? cfg.limit : raw, room);
               end
            end
            rafc_pkg::RAFC_COMP: begin
               next_comp = fmin(lim_hit ? cfg.limit : raw, room);
               if (i_decel && lim_hit) begin
                  next_state = rafc_pkg::RAFC_HOLD;
               end else if (raw == '0 && !regen) begin
                  next_state = rafc_pkg::RAFC_IDLE;
               end
            end
            rafc_pkg::RAFC_HOLD: begin
               next_comp = fmin(cfg.limit, room);
               // hold is a deceleration-only state; bus below level withdraws
               if (o_out_freq <= half_lim || unlimited || !regen ||
                   i_accel || i_const) begin
                  next_state = rafc_pkg::RAFC_COMP;
               end
            end
         endcase
      end
   end

   assign max_hit = tick && (state != rafc_pkg::RAFC_IDLE) && regen && (raw > room);

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         state <= rafc_pkg::RAFC_IDLE;
         comp  <= '0;
      end else begin
         state <= next_state;
         comp  <= next_comp;
      end
   end

   // output frequency, clamped at maximum
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_out_freq <= '0;
      end else begin
         o_out_freq <= fmin(fmin(i_cmd_freq, cfg.maxf) + fmin(comp, room), cfg.maxf);
      end
   end

   // ===========================================
   // indications
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         regen_q        <= 1'b0;
         o_ov_stall_ind <= 1'b0;
         o_stall_prev   <= 1'b0;
      end else begin
         regen_q        <= regen;
         o_ov_stall_ind <= regen;
         o_stall_prev   <= regen;
      end
   end

   // stall output with delay in 0.1 s units
   always_ff @(posedge i_clk) begin
      if (i_sys_rst || !regen_q || unit_cnt == 32'(P_DLY_UNIT - 1)) begin
         unit_cnt <= '0;
      end else begin
         unit_cnt <= unit_cnt + 32'h0000_0001;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_sys_rst || !regen_q) begin
         dly_cnt <= '0;
      end else if (unit_cnt == 32'(P_DLY_UNIT - 1) && dly_cnt != cfg.stdly) begin
         dly_cnt <= dly_cnt + 16'h0001;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_stall_out <= 1'b0;
      end else begin
         o_stall_out <= cfg.stsel && regen_q && (dly_cnt >= cfg.stdly);
      end
   end

   // ===========================================
   // interrupt status, set wins over clear
   assign ev[rafc_pkg::ST_ACT]  = regen && !regen_q;
   assign ev[rafc_pkg::ST_LIM]  = tick && regen && lim_hit && (state != rafc_pkg::RAFC_IDLE);
   assign ev[rafc_pkg::ST_MAXC] = max_hit;

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         status <= '0;
      end else if (i_wr && i_addr == rafc_pkg::REG_CLR) begin
         status <= (status & ~i_wdata[rafc_pkg::ST_W-1:0]) | ev;
      end else begin
         status <= status | ev;
      end
   end

   assign o_irq = |(status & ien);

   // ===========================================
   // checks
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);

   a_mode_off_idle: assert property (
      (cfg.mode == rafc_pkg::MODE_OFF) |=> (comp == '0) && (state == rafc_pkg::RAFC_IDLE))
      else $error("compensation present with function off");

   a_max_freq_clamp: assert property (
      1'b1 |=> (o_out_freq <= $past(cfg.maxf)))
      else $error("output frequency above maximum");

   a_boost_limit_cap: assert property (
      (tick && state == rafc_pkg::RAFC_COMP && !unlimited && !i_decel)
      |=> (comp <= $past(cfg.limit)))
      else $error("boost above limit");

   a_hold_until_half: assert property (
      (state == rafc_pkg::RAFC_HOLD && tick && o_out_freq > half_lim && !unlimited &&
       regen && !i_accel && !i_const &&
       cfg.mode != rafc_pkg::MODE_OFF) |=> (state == rafc_pkg::RAFC_HOLD))
      else $error("hold released early");

   a_stall_ind_prev: assert property (
      regen |=> (o_ov_stall_ind && o_stall_prev) ##1 (o_ov_stall_ind == o_stall_prev))
      else $error("stall indication or prevention missing");

   a_write_lock: assert property (
      (i_wr && extsel && i_addr == rafc_pkg::REG_LEVEL) |=> $stable(cfg.level))
      else $error("setting written while locked");

   a_const_only: assert property (
      (cfg.mode == rafc_pkg::MODE_CONST && !i_const && !i_ov_stall_hold) |=> !o_stall_prev)
      else $error("compensation outside constant speed");

   a_stall_out_sel: assert property (
      (!cfg.stsel || !regen_q) |=> !o_stall_out)
      else $error("stall output without selection or activity");

   a_irq_on_event: assert property (
      (ev[rafc_pkg::ST_ACT] && ien[rafc_pkg::ST_ACT] &&
       !(wr_ok && i_addr == rafc_pkg::REG_IEN)) |=> o_irq)
      else $error("interrupt missing after event");

   a_rdata_pulse: assert property (
      !i_rd |=> (o_rdata == '0))
      else $error("read data outside read slot");
endmodule
`default_nettype wire

// ### design/rafc_pkg.sv
package rafc_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 16;
   localparam int FREQ_W = 16;   // 0.01 Hz units
   localparam int VOLT_W = 10;   // 1 V units
   localparam int PCT_W  = 8;
   // ===========================================
   // register offsets
   localparam logic [ADDR_W-1:0] REG_MODE   = 8'h00;
   localparam logic [ADDR_W-1:0] REG_LEVEL  = 8'h01;
   localparam logic [ADDR_W-1:0] REG_LIMIT  = 8'h02;
   localparam logic [ADDR_W-1:0] REG_VGAIN  = 8'h03;
   localparam logic [ADDR_W-1:0] REG_FGAIN  = 8'h04;
   localparam logic [ADDR_W-1:0] REG_MAXF   = 8'h05;
   localparam logic [ADDR_W-1:0] REG_EXTSEL = 8'h06;
   localparam logic [ADDR_W-1:0] REG_STSEL  = 8'h07;
   localparam logic [ADDR_W-1:0] REG_STDLY  = 8'h08;
   localparam logic [ADDR_W-1:0] REG_STAT   = 8'h09;
   localparam logic [ADDR_W-1:0] REG_CLR    = 8'h0A;
   localparam logic [ADDR_W-1:0] REG_IEN    = 8'h0B;
   localparam logic [ADDR_W-1:0] REG_FREQ   = 8'h0C;
   localparam logic [ADDR_W-1:0] REG_LIVE   = 8'h0D;
   // ===========================================
   // ranges and reset values
   localparam logic [1:0]        MODE_OFF    = 2'h0;
   localparam logic [1:0]        MODE_ALWAYS = 2'h1;
   localparam logic [1:0]        MODE_CONST  = 2'h2;
   localparam logic [VOLT_W-1:0] LEVEL_MIN   = 10'h12C;  // 300 V
   localparam logic [VOLT_W-1:0] LEVEL_MAX   = 10'h320;  // 800 V
   localparam logic [VOLT_W-1:0] LEVEL_RST_L = 10'h190;  // 400 V
   localparam logic [VOLT_W-1:0] LEVEL_RST_H = 10'h30C;  // 780 V
   localparam logic [FREQ_W-1:0] LIMIT_MAX   = 16'h03E8; // 10.00 Hz
   localparam logic [FREQ_W-1:0] LIMIT_RST   = 16'h0258; // 6.00 Hz
   localparam logic [FREQ_W-1:0] LIMIT_OFF   = 16'h270F; // 9999
   localparam logic [FREQ_W-1:0] FREQ_TOP    = 16'hFFFF;
   localparam logic [FREQ_W-1:0] MAXF_RST    = 16'h2EE0; // 120.00 Hz
   localparam logic [PCT_W-1:0]  GAIN_MAX    = 8'hC8;    // 200 %
   localparam logic [PCT_W-1:0]  GAIN_RST    = 8'h64;    // 100 %
   localparam int                GAIN_SHIFT  = 13;
   // status bits
   localparam int ST_ACT  = 0;
   localparam int ST_LIM  = 1;
   localparam int ST_MAXC = 2;
   localparam int ST_W    = 3;
   // ===========================================
   // timing
   localparam int CLK_MHZ        = 10;
   localparam int STEP_PERIOD_US = 1000;
   localparam int STEP_CYC       = STEP_PERIOD_US * CLK_MHZ;
   localparam int DLY_UNIT_MS    = 100;
   localparam int DLY_UNIT_CYC   = DLY_UNIT_MS * 1000 * CLK_MHZ;
   // ===========================================
   // types
   typedef enum logic [2:0] {
      RAFC_IDLE = 3'b001,
      RAFC_COMP = 3'b010,
      RAFC_HOLD = 3'b100
   } rafc_state_t;
   typedef struct packed {
      logic [1:0]        mode;
      logic [VOLT_W-1:0] level;
      logic [FREQ_W-1:0] limit;
      logic [PCT_W-1:0]  vgain;
      logic [PCT_W-1:0]  fgain;
      logic [FREQ_W-1:0] maxf;
      logic              stsel;
      logic [FREQ_W-1:0] stdly;
   } rafc_cfg_t;
endpackage

// ### dv/rafc_drive_model.sv
`timescale 1ns/100ps
`default_nettype none
// ===========================================
// drive side: bus voltage sensing and ramp logic
module rafc_drive_model (
   input  wire logic                        i_clk,
   input  wire logic                        i_sys_rst,
   input  wire logic [rafc_pkg::VOLT_W-1:0] i_target_v,
   input  wire logic [rafc_pkg::FREQ_W-1:0] i_cmd_set,
   input  wire logic                        i_load,
   input  wire logic                        i_ramp,
   output logic      [rafc_pkg::VOLT_W-1:0] o_bus_voltage,
   output logic      [rafc_pkg::FREQ_W-1:0] o_cmd_freq
);
   // sensed bus voltage, one cycle of sensing lag
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_bus_voltage <= 10'h064;
      end else begin
         o_bus_voltage <= i_target_v;
      end
   end
   // commanded frequency, ramps down 0.10 Hz a cycle
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_cmd_freq <= 16'h0000;
      end else if (i_load) begin
         o_cmd_freq <= i_cmd_set;
      end else if (i_ramp && o_cmd_freq >= 16'h000A) begin
         o_cmd_freq <= o_cmd_freq - 16'h000A;
      end
   end
endmodule
`default_nettype wire

// ### dv/rafc_top_tb.sv
`timescale 1ns/100ps
`default_nettype none
module rafc_top_tb;
   logic                        i_clk = 1'b0;
   logic                        i_sys_rst = 1'b1;
   logic [rafc_pkg::ADDR_W-1:0] i_addr = 8'h00;
   logic [rafc_pkg::DATA_W-1:0] i_wdata = 16'h0000;
   logic                        i_wr = 1'b0;
   logic                        i_rd = 1'b0;
   logic                        i_accel = 1'b0;
   logic                        i_const = 1'b1;
   logic                        i_decel = 1'b0;
   logic                        i_ov_stall_hold = 1'b0;
   logic [rafc_pkg::VOLT_W-1:0] tgt_v = 10'h064;
   logic [rafc_pkg::FREQ_W-1:0] cmd_set = 16'h0BB8;
   logic                        load = 1'b1;
   logic                        ramp = 1'b0;
   logic [rafc_pkg::DATA_W-1:0] o_rdata;
   logic [rafc_pkg::VOLT_W-1:0] bus_v;
   logic [rafc_pkg::FREQ_W-1:0] cmd_f;
   logic [rafc_pkg::FREQ_W-1:0] o_out_freq;
   logic                        o_ov_stall_ind;
   logic                        o_stall_prev;
   logic                        o_stall_out;
   logic                        o_irq;
   logic [15:0]                 rd_v;
   logic [15:0]                 rv [6] = '{16'h0000, 16'h0190, 16'h0258, 16'h0064,
                                           16'h0064, 16'h2EE0};
   int                          failures = 0;
   int                          checked = 0;
   int                          cycles = 0;
   int                          i;
   int                          ex;
   int                          vg;
   integer                      seed = 32'hac8933d0;

   always #50 i_clk = ~i_clk;

   rafc_top #(.P_HIGH_VOLT(1'b0), .P_STEP_CYC(8), .P_DLY_UNIT(4)) i_rafc_top (
      .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr), .i_wdata(i_wdata),
      .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_bus_voltage(bus_v),
      .i_cmd_freq(cmd_f), .i_accel(i_accel), .i_const(i_const), .i_decel(i_decel),
      .i_ov_stall_hold(i_ov_stall_hold), .o_out_freq(o_out_freq),
      .o_ov_stall_ind(o_ov_stall_ind), .o_stall_prev(o_stall_prev),
      .o_stall_out(o_stall_out), .o_irq(o_irq));

   rafc_drive_model i_rafc_drive_model (
      .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_target_v(tgt_v), .i_cmd_set(cmd_set),
      .i_load(load), .i_ramp(ramp), .o_bus_voltage(bus_v), .o_cmd_freq(cmd_f));

   // ===========================================
   // reporting
   task complete_run;
      if (failures == 0 && checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   always @(posedge i_clk) begin
      cycles <= cycles + 1;
      if (cycles == 60000) begin
         failures = failures + 1;
         complete_run;
      end
   end
   task cmp16(input logic [15:0] got, input logic [15:0] exp);
      checked = checked + 1;
      if (got !== exp) begin
         failures = failures + 1;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task cmp1(input logic got, input logic exp);
      cmp16({15'h0000, got}, {15'h0000, exp});
   endtask
   // ===========================================
   // register bus and helpers
   task wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge i_clk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_clk);
      i_wr <= 1'b0;
   endtask
   task rd(input logic [7:0] a, output logic [15:0] d);
      @(posedge i_clk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1 d = o_rdata;
   endtask
   task chk_reg(input logic [7:0] a, input logic [15:0] e);
      rd(a, rd_v);
      cmp16(rd_v, e);
   endtask
   task cyc(input int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask
   task wait_up(input logic [15:0] base);
      int k;
      for (k = 0; k < 40 && o_out_freq === base; k++) cyc(1);
   endtask
   function automatic logic [15:0] step(input int e, input int v, input int f);
      return 16'((e * v * f) >>> 13);
   endfunction
   task set_v(input logic [9:0] v);
      @(posedge i_clk);
      tgt_v <= v;
   endtask
   // ===========================================
   // scenarios
   initial begin
      repeat (10) @(posedge i_clk);
      i_sys_rst <= 1'b0;
      for (i = 0; i < 6; i++) chk_reg(8'(i), rv[i]);
      chk_reg(8'h20, 16'h0000);
      // out-of-range writes leave settings alone
      wr(rafc_pkg::REG_MODE, 16'h0003);
      wr(rafc_pkg::REG_LEVEL, 16'h012B);
      wr(rafc_pkg::REG_LEVEL, 16'h0321);
      wr(rafc_pkg::REG_LIMIT, 16'h03E9);
      wr(rafc_pkg::REG_VGAIN, 16'h00C9);
      for (i = 0; i < 5; i++) chk_reg(8'(i), rv[i]);
      // locked by extended display selection
      wr(rafc_pkg::REG_EXTSEL, 16'h0001);
      wr(rafc_pkg::REG_LIMIT, 16'h01F4);
      chk_reg(rafc_pkg::REG_LIMIT, 16'h0258);
      wr(rafc_pkg::REG_LEVEL, 16'h01F4);
      chk_reg(rafc_pkg::REG_LEVEL, 16'h0190);
      wr(rafc_pkg::REG_EXTSEL, 16'h0000);
      // mode 0 ignores a high bus
      set_v(10'h1F4);
      cyc(40);
      cmp16(o_out_freq, 16'h0BB8);
      cmp1(o_ov_stall_ind, 1'b0);
      // first boost step follows excess and gain
      for (i = 0; i < 4; i++) begin
         ex = 5 + ($random(seed) & 31);
         vg = 100 + ($random(seed) & 63);
         wr(rafc_pkg::REG_MODE, 16'h0000);
         wr(rafc_pkg::REG_VGAIN, 16'(vg));
         set_v(10'(400 + ex));
         cyc(3);
         wr(rafc_pkg::REG_MODE, 16'h0001);
         wait_up(16'h0BB8);
         cmp16(o_out_freq, 16'h0BB8 + step(ex, vg, 100));
      end
      // bus exactly at the level, then just below
      set_v(10'h190);
      cyc(3);
      cmp1(o_ov_stall_ind, 1'b1);
      set_v(10'h18F);
      cyc(3);
      cmp1(o_ov_stall_ind, 1'b0);
      // boost capped at the limit
      wr(rafc_pkg::REG_VGAIN, 16'h00C8);
      set_v(10'h1B8);
      cyc(200);
      cmp16(o_out_freq, 16'h0E10);
      cmp1(o_ov_stall_ind, 1'b1);
      cmp1(o_stall_prev, 1'b1);
      cmp1(o_stall_out, 1'b1);
      rd(rafc_pkg::REG_STAT, rd_v);
      cmp1(rd_v[rafc_pkg::ST_LIM], 1'b1);
      wr(rafc_pkg::REG_STSEL, 16'h0000);
      cyc(2);
      cmp1(o_stall_out, 1'b0);
      wr(rafc_pkg::REG_STSEL, 16'h0001);
      // decel: limit held while output above half the limit
      @(posedge i_clk);
      i_const <= 1'b0;
      i_decel <= 1'b1;
      load <= 1'b0;
      ramp <= 1'b1;
      for (i = 0; i < 400 && cmd_f > 16'h03E8; i++) cyc(1);
      @(posedge i_clk);
      ramp <= 1'b0;
      cyc(3);
      cmp16(o_out_freq, cmd_f + 16'h0258);
      // bus below level: boost withdrawn
      @(posedge i_clk);
      i_decel <= 1'b0;
      i_const <= 1'b1;
      tgt_v <= 10'h168;
      cyc(200);
      cmp16(o_out_freq, cmd_f);
      cmp1(o_ov_stall_ind, 1'b0);
      // mode 2: accel ignored, stall hold in decel compensates
      @(posedge i_clk);
      load <= 1'b1;
      wr(rafc_pkg::REG_MODE, 16'h0002);
      @(posedge i_clk);
      i_const <= 1'b0;
      i_accel <= 1'b1;
      tgt_v <= 10'h1B8;
      cyc(100);
      cmp16(o_out_freq, 16'h0BB8);
      cmp1(o_ov_stall_ind, 1'b0);
      @(posedge i_clk);
      i_accel <= 1'b0;
      i_decel <= 1'b1;
      i_ov_stall_hold <= 1'b1;
      cyc(100);
      cmp1(o_out_freq > 16'h0BB8, 1'b1);
      @(posedge i_clk);
      i_decel <= 1'b0;
      i_ov_stall_hold <= 1'b0;
      i_const <= 1'b1;
      // clamp at maximum frequency, interrupt masked then enabled
      wr(rafc_pkg::REG_MODE, 16'h0001);
      wr(rafc_pkg::REG_MAXF, 16'h0BEA);
      cyc(100);
      cmp16(o_out_freq, 16'h0BEA);
      cmp1(o_irq, 1'b0);
      wr(rafc_pkg::REG_IEN, 16'h0005);
      cyc(1);
      cmp1(o_irq, 1'b1);
      // no limit with 9999
      wr(rafc_pkg::REG_MAXF, 16'h2EE0);
      wr(rafc_pkg::REG_LIMIT, 16'h270F);
      cyc(200);
      rd(rafc_pkg::REG_LIVE, rd_v);
      cmp1(rd_v > 16'h0258, 1'b1);
      // level kept above the normal bus, then status cleared
      set_v(10'h168);
      cyc(300);
      wr(rafc_pkg::REG_CLR, 16'h0007);
      cyc(1);
      cmp1(o_irq, 1'b0);
      chk_reg(rafc_pkg::REG_STAT, 16'h0000);
      // fresh activity raises the enabled interrupt again
      set_v(10'h1B8);
      cyc(3);
      cmp1(o_irq, 1'b1);
      complete_run;
   end
endmodule
`default_nettype wire
